// File: logic/cic_gauge.sv
// The Avalon-MM interface to the registers was left to the implementer.
module cic_gauge
  import cic_pkg::*;
#(
  parameter int unsigned TICK_CYC  = cic_pkg::TICK_CYCLES,
  parameter int unsigned SLEEP_CYC = cic_pkg::SLEEP_CYCLES
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  // front end results, same clock
  input  wire logic        chgValid,
  input  wire logic [15:0] chgSample,
  input  wire logic        offValid,
  input  wire logic [15:0] offSample,
  input  wire logic        voltValid,
  input  wire logic [15:0] voltRaw,
  input  wire logic [15:0] voltOffset,
  input  wire logic        condChange,
  input  wire logic        checksumOk,
  // communication line level, asynchronous
  input  wire logic        commLine,
  // outputs
  output logic             calMode,
  output logic             sleepMode,
  output logic             irq
);
  import cic_pkg::*;

  typedef struct packed {
    cic_state_t        st;
    logic [31:0]       tickCnt;
    logic [5:0]        phaseTicks;
    logic [5:0]        delayTicks;
    logic [5:0]        winTicks;
    logic              fullReset;
    logic              firstPeriod;
    logic              shortcut;
    logic              calReqPend;
    logic [7:0]        ctrl;
    logic [7:0]        magnitude_threshold_filter;
    logic [15:0]       userOff;
    logic [15:0]       edv1;
    logic [15:0]       edvF;
    logic [15:0]       designCap;
    logic [15:0]       standbyCur;
    logic [15:0]       atRateCur;
    logic [31:0]       curSum;
    logic [15:0]       curCnt;
    logic [31:0]       avgNum;
    logic [15:0]       avgDen;
    logic [15:0]       current;
    logic [31:0]       offSum;
    logic [15:0]       offCnt;
    logic [31:0]       calNum;
    logic [15:0]       calDen;
    logic [15:0]       intOff;
    logic [15:0]       capacity;
    logic [15:0]       capFrac;
    logic [15:0]       volt;
    logic              edv1Hit;
    logic              edvFHit;
    logic [15:0]       tteSb;
    logic [15:0]       tteMs;
    logic [15:0]       tteAr;
    logic              divBusy;
    logic [2:0]        divJob;
    logic [JOB_W-1:0]  divPend;
    logic [31:0]       divRem;
    logic [31:0]       divQuo;
    logic [31:0]       divDen;
    logic [5:0]        divCnt;
    logic              divNeg;
    logic              commS1;
    logic              commS2;
    logic [31:0]       sleepCnt;
    logic              sleep;
    logic [IRQ_W-1:0]  irqStat;
    logic [IRQ_W-1:0]  irqMask;
    logic              irq;
    logic              waitReq;
    logic [31:0]       readData;
    logic              calMode;
  } cic_core_t;

  cic_core_t s_q;
  cic_core_t s_d;

  // helpers
  function automatic logic [31:0] absv(input logic [31:0] v);
    absv = v[31] ? 32'(-v) : v;
  endfunction

  function automatic logic [15:0] sat16(input logic [31:0] mag, input logic neg);
    logic [15:0] m;
    m = (mag > 32'h00007fff) ? 16'h7fff : mag[15:0];
    sat16 = neg ? 16'(-m) : m;
  endfunction

  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    beMerge = r;
  endfunction

  logic              tickEn;
  logic              wrEn;
  logic [31:0]       wrWord;
  logic [7:0]        wordAddr;
  logic [31:0]       rdMux;
  logic signed [17:0] corr;
  logic [17:0]       mag;
  logic [17:0]       thresh;
  logic              pass;
  logic [15:0]       capNext;
  logic [15:0]       fracNext;
  logic [IRQ_W-1:0]  irqSet;
  logic [32:0]       divTmp;
  logic [31:0]       tteNum;
  logic [31:0]       jobNum;
  logic [31:0]       jobDen;
  logic              jobNeg;
  logic [2:0]        jobSel;
  logic [31:0]       prevWord;

  always_comb
  begin
    s_d      = s_q;
    irqSet   = '0;
    tickEn   = (s_q.tickCnt == 32'(TICK_CYC - 1));
    wordAddr = {avsAddress[7:2], 2'b00};
    wrEn     = avsWrite && !s_q.waitReq;
    corr     = 18'sd0;
    mag      = 18'd0;
    thresh   = 18'd0;
    pass     = 1'b0;
    capNext  = s_q.capacity;
    fracNext = s_q.capFrac;
    divTmp   = 33'd0;
    tteNum   = s_q.capacity * TTE_SCALE;
    jobNum   = 32'd0;
    jobDen   = 32'd0;
    jobNeg   = 1'b0;
    jobSel   = 3'd0;
    prevWord = 32'd0;
    wrWord   = 32'd0;

    // read mux, unmapped reads zero
    case (wordAddr)
      ADDR_CTRL:     rdMux = {24'h000000, s_q.ctrl};
      ADDR_STATUS:   rdMux = {26'h0000000, s_q.edvFHit, s_q.edv1Hit,
                              s_q.st == CIC_QSETTLE || s_q.st == CIC_QMEAS,
                              s_q.sleep, s_q.fullReset, s_q.calMode};
      ADDR_DMF:      rdMux = {24'h000000, s_q.magnitude_threshold_filter};
      ADDR_USEROFF:  rdMux = {16'h0000, s_q.userOff};
      ADDR_EDV1:     rdMux = {16'h0000, s_q.edv1};
      ADDR_EDVF:     rdMux = {16'h0000, s_q.edvF};
      ADDR_DESCAP:   rdMux = {16'h0000, s_q.designCap};
      ADDR_SBCUR:    rdMux = {16'h0000, s_q.standbyCur};
      ADDR_ARCUR:    rdMux = {16'h0000, s_q.atRateCur};
      ADDR_CURRENT:  rdMux = {16'h0000, s_q.current};
      ADDR_CAPACITY: rdMux = {16'h0000, s_q.capacity};
      ADDR_VOLT:     rdMux = {16'h0000, s_q.volt};
      ADDR_TTE_SB:   rdMux = {16'h0000, s_q.tteSb};
      ADDR_TTE_MEAS: rdMux = {16'h0000, s_q.tteMs};
      ADDR_TTE_AR:   rdMux = {16'h0000, s_q.tteAr};
      ADDR_INTOFF:   rdMux = {16'h0000, s_q.intOff};
      ADDR_IRQSTAT:  rdMux = {27'h0000000, s_q.irqStat};
      ADDR_IRQMASK:  rdMux = {27'h0000000, s_q.irqMask};
      default:       rdMux = 32'h00000000;
    endcase

    // bus handshake: one wait cycle, then data and ack together
    if ((avsRead || avsWrite) && s_q.waitReq)
    begin
      s_d.waitReq  = 1'b0;
      s_d.readData = rdMux;
    end
    else
      s_d.waitReq = 1'b1;

    // time base, one tick per calibration period
    s_d.tickCnt = tickEn ? 32'd0 : s_q.tickCnt + 32'd1;
    if (tickEn && s_q.delayTicks != 6'd0)
      s_d.delayTicks = s_q.delayTicks - 6'd1;

    // calibration sequencer
    if (condChange)
      s_d.calReqPend = 1'b1;
    case (s_q.st)
      CIC_BOOT:
      begin
        s_d.tickCnt   = 32'd0;
        s_d.fullReset = !checksumOk;
        if (!checksumOk)
        begin
          s_d.st          = CIC_QSETTLE;
          s_d.firstPeriod = 1'b1;
          s_d.delayTicks  = FULL_DELAY_TICKS;
          s_d.capacity    = WORD16_RST;
        end
        else
        begin
          s_d.st         = CIC_IDLE;
          s_d.calReqPend = 1'b1;
        end
      end
      CIC_QSETTLE:
        if (tickEn)
        begin
          s_d.firstPeriod = 1'b0;
          if (s_q.shortcut)
          begin
            s_d.calNum          = s_q.offSum;
            s_d.calDen          = s_q.offCnt;
            s_d.divPend[JOB_OFF] = 1'b1;
            s_d.st              = CIC_IDLE;
            irqSet[IRQ_CALDONE] = 1'b1;
          end
          else
            s_d.st = CIC_QMEAS; // first period discarded
          s_d.offSum = 32'd0;
          s_d.offCnt = 16'd0;
        end
      CIC_QMEAS:
        if (tickEn)
        begin
          s_d.calNum           = s_q.offSum;
          s_d.calDen           = s_q.offCnt;
          s_d.divPend[JOB_OFF] = 1'b1;
          s_d.st               = CIC_IDLE;
          irqSet[IRQ_CALDONE]  = 1'b1;
        end
      CIC_FULL:
        if (tickEn)
        begin
          if (s_q.phaseTicks == FULL_CAL_TICKS - 6'd1)
          begin
            s_d.calNum           = s_q.offSum;
            s_d.calDen           = s_q.offCnt;
            s_d.divPend[JOB_OFF] = 1'b1;
            s_d.st               = CIC_IDLE;
            s_d.winTicks         = 6'd0; // fresh window after freeze
            s_d.curSum           = 32'd0;
            s_d.curCnt           = 16'd0;
            irqSet[IRQ_CALDONE]  = 1'b1;
          end
          else
            s_d.phaseTicks = s_q.phaseTicks + 6'd1;
        end
      CIC_IDLE:
        if (s_q.calReqPend && s_q.delayTicks == 6'd0 && !condChange)
        begin
          s_d.st         = CIC_FULL;
          s_d.calReqPend = 1'b0;
          s_d.phaseTicks = 6'd0;
          s_d.offSum     = 32'd0;
          s_d.offCnt     = 16'd0;
        end
      default: s_d.st = CIC_IDLE;
    endcase
    s_d.calMode = (s_d.st != CIC_IDLE) && (s_d.st != CIC_BOOT);

    // offset samples gathered while calibrating
    if (offValid && s_q.calMode && s_d.st == s_q.st)
    begin
      s_d.offSum = s_q.offSum + {{16{offSample[15]}}, offSample};
      s_d.offCnt = s_q.offCnt + 16'd1;
    end

    // charge samples: offset correction, filter, capacity
    if (chgValid)
    begin
      corr   = $signed({{2{chgSample[15]}}, chgSample})
             - $signed({{2{s_q.intOff[15]}}, s_q.intOff})
             - $signed({{2{s_q.userOff[15]}}, s_q.userOff});
      mag    = corr[17] ? 18'(-corr) : 18'(corr);
      thresh = 18'(s_q.magnitude_threshold_filter * DMF_STEP_LSB);
      pass   = (s_q.magnitude_threshold_filter == 8'h00) ? (corr != 18'sd0) : (mag >= thresh);
      if (pass)
      begin
        fracNext = s_q.capFrac + corr[15:0];
        if (!fracNext[15] && fracNext >= CAP_UNIT_COUNTS)
        begin
          fracNext = fracNext - CAP_UNIT_COUNTS;
          if (s_q.capacity != 16'hffff)
            capNext = s_q.capacity + 16'd1;
        end
        else if (fracNext[15] && 16'(-fracNext) >= CAP_UNIT_COUNTS)
        begin
          fracNext = fracNext + CAP_UNIT_COUNTS;
          if (s_q.capacity != 16'h0000)
            capNext = s_q.capacity - 16'd1;
        end
        s_d.capacity = capNext;
        s_d.capFrac  = fracNext;
      end
      if (s_q.st != CIC_FULL)
      begin
        s_d.curSum = s_q.curSum + {{14{corr[17]}}, corr};
        s_d.curCnt = s_q.curCnt + 16'd1;
      end
    end

    // averaging window close, held off during full calibration
    if (tickEn && s_q.st != CIC_FULL && s_q.st != CIC_BOOT)
    begin
      if (s_q.winTicks == AVG_WIN_TICKS - 6'd1)
      begin
        s_d.avgNum           = s_d.curSum;
        s_d.avgDen           = s_d.curCnt;
        s_d.divPend[JOB_AVG] = 1'b1;
        s_d.curSum           = 32'd0;
        s_d.curCnt           = 16'd0;
        s_d.winTicks         = 6'd0;
        irqSet[IRQ_WINDOW]   = 1'b1;
      end
      else
        s_d.winTicks = s_q.winTicks + 6'd1;
    end

    // voltage and end-of-discharge alignment
    if (voltValid)
    begin
      s_d.volt = voltRaw - voltOffset;
      if (s_d.volt <= s_q.edvF && !s_q.edvFHit)
      begin
        s_d.capacity     = WORD16_RST;
        s_d.capFrac      = WORD16_RST;
        s_d.edvFHit      = 1'b1;
        s_d.edv1Hit      = 1'b1;
        irqSet[IRQ_EDVF] = 1'b1;
      end
      else if (s_d.volt <= s_q.edv1 && !s_q.edv1Hit)
      begin
        s_d.capacity     = s_q.designCap >> EDV1_SHIFT;
        s_d.capFrac      = WORD16_RST;
        s_d.edv1Hit      = 1'b1;
        irqSet[IRQ_EDV1] = 1'b1;
      end
      else if (s_d.volt > s_q.edv1)
      begin
        s_d.edv1Hit = 1'b0;
        s_d.edvFHit = 1'b0;
      end
    end

    // shared restoring divider for averages and run times
    if (s_q.divBusy)
    begin
      divTmp       = {s_q.divRem, s_q.divQuo[31]};
      s_d.divQuo   = {s_q.divQuo[30:0], 1'b0};
      s_d.divRem   = divTmp[31:0];
      if (divTmp >= {1'b0, s_q.divDen})
      begin
        s_d.divRem    = 32'(divTmp - {1'b0, s_q.divDen});
        s_d.divQuo[0] = 1'b1;
      end
      s_d.divCnt = s_q.divCnt + 6'd1;
      if (s_q.divCnt == DIV_STEPS - 6'd1)
      begin
        s_d.divBusy = 1'b0;
        case (s_q.divJob)
          3'(JOB_AVG):
          begin
            if (s_q.st != CIC_FULL)
              s_d.current = sat16(s_d.divQuo, s_q.divNeg);
            s_d.divPend[JOB_TTE_AR:JOB_TTE_SB] = 3'b111;
          end
          3'(JOB_OFF):    s_d.intOff = sat16(s_d.divQuo, s_q.divNeg);
          3'(JOB_TTE_SB): s_d.tteSb = (|s_d.divQuo[31:16]) ? TTE_RST : s_d.divQuo[15:0];
          3'(JOB_TTE_MS): s_d.tteMs = (|s_d.divQuo[31:16]) ? TTE_RST : s_d.divQuo[15:0];
          default:        s_d.tteAr = (|s_d.divQuo[31:16]) ? TTE_RST : s_d.divQuo[15:0];
        endcase
      end
    end
    else if (s_q.divPend != '0)
    begin
      for (int j = JOB_W - 1; j >= 0; j--)
        if (s_q.divPend[j]) jobSel = 3'(j);
      case (jobSel)
        3'(JOB_AVG): begin jobNum = s_q.avgNum; jobDen = {16'h0000, s_q.avgDen}; end
        3'(JOB_OFF): begin jobNum = s_q.calNum; jobDen = {16'h0000, s_q.calDen}; end
        3'(JOB_TTE_SB): begin jobNum = tteNum; jobDen = absv({{16{s_q.standbyCur[15]}}, s_q.standbyCur}); end
        3'(JOB_TTE_MS): begin jobNum = tteNum; jobDen = absv({{16{s_q.current[15]}}, s_q.current}); end
        default: begin jobNum = tteNum; jobDen = absv({{16{s_q.atRateCur[15]}}, s_q.atRateCur}); end
      endcase
      jobNeg = (jobSel <= 3'(JOB_OFF)) && jobNum[31];
      s_d.divPend[jobSel] = 1'b0;
      if (jobDen != 32'd0)
      begin
        s_d.divBusy = 1'b1;
        s_d.divJob  = jobSel;
        s_d.divQuo  = (jobSel <= 3'(JOB_OFF)) ? absv(jobNum) : jobNum;
        s_d.divRem  = 32'd0;
        s_d.divDen  = jobDen;
        s_d.divNeg  = jobNeg;
        s_d.divCnt  = 6'd0;
      end
      else if (jobSel == 3'(JOB_TTE_SB))
        s_d.tteSb = TTE_RST; // no load, run time unbounded
      else if (jobSel == 3'(JOB_TTE_MS))
        s_d.tteMs = TTE_RST;
      else if (jobSel == 3'(JOB_TTE_AR))
        s_d.tteAr = TTE_RST;
    end

    // sleep detect on synchronised communication line
    s_d.commS1 = commLine;
    s_d.commS2 = s_q.commS1;
    if (s_q.commS2)
    begin
      s_d.sleepCnt = 32'd0;
      s_d.sleep    = 1'b0;
    end
    else if (!s_q.sleep)
    begin
      s_d.sleepCnt = s_q.sleepCnt + 32'd1;
      if (s_q.sleepCnt == 32'(SLEEP_CYC - 1))
      begin
        s_d.sleep         = 1'b1;
        irqSet[IRQ_SLEEP] = 1'b1;
      end
    end

    // register writes
    if (wrEn)
    begin
      case (wordAddr)
        ADDR_CTRL:    prevWord = {24'h000000, s_q.ctrl};
        ADDR_DMF:     prevWord = {24'h000000, s_q.magnitude_threshold_filter};
        ADDR_USEROFF: prevWord = {16'h0000, s_q.userOff};
        ADDR_EDV1:    prevWord = {16'h0000, s_q.edv1};
        ADDR_EDVF:    prevWord = {16'h0000, s_q.edvF};
        ADDR_DESCAP:  prevWord = {16'h0000, s_q.designCap};
        ADDR_SBCUR:   prevWord = {16'h0000, s_q.standbyCur};
        ADDR_ARCUR:   prevWord = {16'h0000, s_q.atRateCur};
        ADDR_IRQMASK: prevWord = {27'h0000000, s_q.irqMask};
        default:      prevWord = 32'h00000000;
      endcase
      wrWord = beMerge(prevWord, avsWriteData, avsByteEnable);
      case (wordAddr)
        ADDR_CTRL:
        begin
          s_d.ctrl = wrWord[7:0];
          if (wrWord[CTRL_SHORTCUT_BIT] && s_q.firstPeriod && s_q.st == CIC_QSETTLE)
            s_d.shortcut = 1'b1;
          if (wrWord[CTRL_CALREQ_BIT])
            s_d.calReqPend = 1'b1;
        end
        ADDR_DMF:     s_d.magnitude_threshold_filter        = wrWord[7:0];
        ADDR_USEROFF: s_d.userOff    = wrWord[15:0];
        ADDR_EDV1:    s_d.edv1       = wrWord[15:0];
        ADDR_EDVF:    s_d.edvF       = wrWord[15:0];
        ADDR_DESCAP:  s_d.designCap  = wrWord[15:0];
        ADDR_SBCUR:   s_d.standbyCur = wrWord[15:0];
        ADDR_ARCUR:   s_d.atRateCur  = wrWord[15:0];
        ADDR_IRQSTAT: s_d.irqStat    = s_q.irqStat & ~(avsWriteData[IRQ_W-1:0]
                                       & {IRQ_W{avsByteEnable[0]}});
        ADDR_IRQMASK: s_d.irqMask    = wrWord[IRQ_W-1:0];
        default:      s_d.ctrl       = s_q.ctrl;
      endcase
    end

    // sticky events, set wins over clear
    s_d.irqStat = s_d.irqStat | irqSet;
    s_d.irq     = |(s_d.irqStat & s_d.irqMask);
  end

  // single state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q            <= '0;
      s_q.st         <= CIC_BOOT;
      s_q.ctrl       <= CTRL_RST;
      s_q.magnitude_threshold_filter        <= DMF_RST;
      s_q.tteSb      <= TTE_RST;
      s_q.tteMs      <= TTE_RST;
      s_q.tteAr      <= TTE_RST;
      s_q.waitReq    <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from flops
  assign avsReadData    = s_q.readData;
  assign avsWaitRequest = s_q.waitReq;
  assign calMode        = s_q.calMode;
  assign sleepMode      = s_q.sleep;
  assign irq            = s_q.irq;

endmodule

// File: logic/cic_pkg.sv
package cic_pkg;

  // clock and time base
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned CAL_PERIOD_MS  = 1280;
  localparam int unsigned FULL_CAL_MS    = 5120;
  localparam int unsigned AVG_WINDOW_MS  = 5120;
  localparam int unsigned FULL_DELAY_MS  = 40000;
  localparam int unsigned SLEEP_DETECT_US = 2000;
  localparam int unsigned TICK_CYCLES    = CAL_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned SLEEP_CYCLES   = SLEEP_DETECT_US * CLK_MHZ;
  localparam logic [5:0]  FULL_CAL_TICKS = 6'(FULL_CAL_MS / CAL_PERIOD_MS);
  localparam logic [5:0]  AVG_WIN_TICKS  = 6'(AVG_WINDOW_MS / CAL_PERIOD_MS);
  localparam logic [5:0]  FULL_DELAY_TICKS =
    6'((FULL_DELAY_MS + CAL_PERIOD_MS - 1) / CAL_PERIOD_MS);

  // measurement scaling
  localparam int unsigned DMF_STEP_NV    = 4900;
  localparam int unsigned INT_LSB_NV     = 4900;
  localparam logic [7:0]  DMF_STEP_LSB   = 8'(DMF_STEP_NV / INT_LSB_NV);
  localparam int unsigned CAP_RES_NVH    = 3570;
  localparam logic [15:0] CAP_UNIT_COUNTS = 16'h0010;
  localparam int unsigned EDV1_SHIFT     = 4;
  localparam logic [15:0] TTE_SCALE      = 16'(CAP_RES_NVH * 60 / INT_LSB_NV);

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_DMF      = 8'h08;
  localparam logic [7:0] ADDR_USEROFF  = 8'h0c;
  localparam logic [7:0] ADDR_EDV1     = 8'h10;
  localparam logic [7:0] ADDR_EDVF     = 8'h14;
  localparam logic [7:0] ADDR_DESCAP   = 8'h18;
  localparam logic [7:0] ADDR_SBCUR    = 8'h1c;
  localparam logic [7:0] ADDR_ARCUR    = 8'h20;
  localparam logic [7:0] ADDR_CURRENT  = 8'h24;
  localparam logic [7:0] ADDR_CAPACITY = 8'h28;
  localparam logic [7:0] ADDR_VOLT     = 8'h2c;
  localparam logic [7:0] ADDR_TTE_SB   = 8'h30;
  localparam logic [7:0] ADDR_TTE_MEAS = 8'h34;
  localparam logic [7:0] ADDR_TTE_AR   = 8'h38;
  localparam logic [7:0] ADDR_INTOFF   = 8'h3c;
  localparam logic [7:0] ADDR_IRQSTAT  = 8'h40;
  localparam logic [7:0] ADDR_IRQMASK  = 8'h44;

  // reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  DMF_RST    = 8'h00;
  localparam logic [15:0] WORD16_RST = 16'h0000;
  localparam logic [15:0] TTE_RST    = 16'hffff;

  // field positions
  localparam int unsigned CTRL_SHORTCUT_BIT = 0;
  localparam int unsigned CTRL_CALREQ_BIT   = 1;
  localparam int unsigned STAT_CALACT_BIT   = 0;
  localparam int unsigned STAT_FULLRST_BIT  = 1;
  localparam int unsigned STAT_SLEEP_BIT    = 2;
  localparam int unsigned STAT_QUICK_BIT    = 3;
  localparam int unsigned STAT_EDV1_BIT     = 4;
  localparam int unsigned STAT_EDVF_BIT     = 5;
  localparam int unsigned IRQ_W       = 5;
  localparam int unsigned IRQ_CALDONE = 0;
  localparam int unsigned IRQ_WINDOW  = 1;
  localparam int unsigned IRQ_EDV1    = 2;
  localparam int unsigned IRQ_EDVF    = 3;
  localparam int unsigned IRQ_SLEEP   = 4;

  // shared divider jobs
  localparam int unsigned JOB_W       = 5;
  localparam int unsigned JOB_AVG     = 0;
  localparam int unsigned JOB_OFF     = 1;
  localparam int unsigned JOB_TTE_SB  = 2;
  localparam int unsigned JOB_TTE_MS  = 3;
  localparam int unsigned JOB_TTE_AR  = 4;
  localparam logic [5:0]  DIV_STEPS   = 6'd32;

  typedef enum logic [2:0] {
    CIC_BOOT,
    CIC_IDLE,
    CIC_QSETTLE,
    CIC_QMEAS,
    CIC_FULL
  } cic_state_t;

endpackage

// File: tb/cic_front_model.sv
module cic_front_model (
  // clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // bench controls
  input wire logic [15:0]  offIn,
  input wire logic         kick,
  input wire logic [15:0]  kickVal,
  input wire logic [15:0]  voltIn,
  // converter results
  output logic             offValid,
  output logic [15:0]      offSample,
  output logic             chgValid,
  output logic [15:0]      chgSample,
  output logic             voltValid,
  output logic [15:0]      voltRaw,
  output logic [15:0]      voltOffset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  assign voltOffset = 16'h0010;
  // periodic offset and voltage, charge on request; idle offset and charge data inverted
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ph <= 3'h0;
      {offValid, chgValid, voltValid} <= 3'h0;
    end
    else
    begin
      ph <= ph + 3'h1;
      offValid <= ph == 3'h2;
      offSample <= ph == 3'h2 ? offIn : ~offSample;
      chgValid <= kick;
      chgSample <= kick ? kickVal : ~chgSample;
      voltValid <= ph == 3'h5;
      voltRaw <= voltIn + voltOffset;
    end
endmodule

// File: tb/cic_gauge_checker.sv
module cic_gauge_checker
  import cic_pkg::*;
#(parameter int unsigned SLEEP_CYC = 20)(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register bus
  input wire logic [7:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  // status lines
  input wire logic        commLine,
  input wire logic        calMode,
  input wire logic        sleepMode
);
  timeunit 1ns;
  timeprecision 1ps;
  int   lowCnt;
  logic rdAns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // read answer strobe
  assign rdAns = avsRead && !avsWaitRequest;
  // low time of the line
  always_ff @(posedge clk or posedge rst)
    if (rst)
      lowCnt <= 0;
    else
      lowCnt <= commLine ? 0 : lowCnt + 1;
  AST_WAIT_ONE: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("wait low too long");
  AST_WAIT_ANS: assert property ($rose(avsRead || avsWrite) |-> ##[1:2] !avsWaitRequest)
    else $error("no bus answer");
  AST_UNMAP: assert property (rdAns && avsAddress == 8'hfc |-> avsReadData == 32'h0)
    else $error("unmapped read not zero");
  AST_BOOT_CAL: assert property ($fell(rst) |-> ##[1:3] calMode)
    else $error("no calibration after reset");
  AST_CAL_HOLD: assert property ($rose(calMode) |-> calMode [*8])
    else $error("calibration too short");
  AST_CAL_END: assert property ($rose(calMode) |-> ##[1:600] !calMode)
    else $error("calibration never ends");
  AST_STAT_CAL: assert property (rdAns && avsAddress == ADDR_STATUS |->
    avsReadData[STAT_CALACT_BIT] == $past(calMode))
    else $error("status flag differs");
  AST_SLEEP_IN: assert property (lowCnt == SLEEP_CYC + 6 |-> sleepMode)
    else $error("no sleep");
  AST_SLEEP_OUT: assert property ($rose(commLine) |-> ##[2:5] !sleepMode)
    else $error("sleep kept");
endmodule
bind cic_gauge cic_gauge_checker #(.SLEEP_CYC(SLEEP_CYC)) cic_gauge_checker_i (
  .clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .commLine(commLine), .calMode(calMode), .sleepMode(sleepMode));

// File: tb/cic_gauge_tb_top.sv
module cic_gauge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cic_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, kick = 1'b0;
  logic        checksumOk = 1'b0, commLine = 1'b1, condChange = 1'b0;
  logic        avsWaitRequest, chgValid, offValid, voltValid, calMode, sleepMode, irq;
  logic [7:0]  avsAddress = 8'h00;
  logic [31:0] avsWriteData = 32'h0, avsReadData, q;
  logic [15:0] chgSample, offSample, voltRaw, voltOffset;
  logic [15:0] offIn = 16'h0, kickVal = 16'h0, voltIn = 16'h1000;
  int          errorCnt = 0, samplesChecked = 0, seed = 36982, capFrac = 0, offA, offB;
  int          cap = 0, c, sum = 0;
  int          corr[$] = '{18, 2, -2, 13};
  always #2.5 clk = ~clk;
  cic_gauge #(.TICK_CYC(64), .SLEEP_CYC(20)) cic_gauge_i (.clk, .rst, .avsAddress, .avsRead,
    .avsWrite, .avsWriteData, .avsByteEnable(4'hf), .avsReadData, .avsWaitRequest, .chgValid,
    .chgSample, .offValid, .offSample, .voltValid, .voltRaw, .voltOffset, .condChange,
    .checksumOk, .commLine, .calMode, .sleepMode, .irq);
  cic_front_model cic_front_model_i (.clk, .rst, .offIn, .kick, .kickVal, .voltIn, .offValid,
    .offSample, .chgValid, .chgSample, .voltValid, .voltRaw, .voltOffset);
  // verdict
  task giveVerdict;
    $display("errors %0d checks %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    samplesChecked++;
    if (s !== e)
    begin
      errorCnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bus cycle, held until waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    @(posedge clk);
    while (avsWaitRequest !== 1'b0)
    begin
      @(posedge clk);
      n++;
      if (n > 20)
      begin
        errorCnt++;
        giveVerdict;
      end
    end
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk); // idle edge between requests
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task rstDo(input logic ok);
    checksumOk <= ok;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    offIn <= 16'(offA);
    cyc(1);
  endtask
  // main sequence
  initial
  begin
    offA = 1 + ($random(seed) & 15);
    offB = offA + 3 + ($random(seed) & 7);
    rstDo(1'b0);
    rd(ADDR_STATUS, 32'h0b, 32'h0b);
    for (int i = 0; i < 3; i++) rd(ADDR_TTE_SB + 8'(4 * i), 32'hffffffff, 32'hffff);
    cyc(40);
    offIn <= 16'(offB);
    cyc(36);
    bus(1'b1, ADDR_CTRL, 32'h1);
    chk(calMode, 1'b1);
    cyc(97);
    chk(calMode, 1'b0);
    rd(ADDR_INTOFF, 32'hffff, 32'(offB));
    bus(1'b1, ADDR_DMF, 32'h3);
    bus(1'b1, ADDR_USEROFF, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      if (i == 4) bus(1'b1, ADDR_DMF, 32'h0);
      c = (i == 4) ? 1 : corr[i];
      kickVal <= 16'(c + offB + 2);
      kick <= 1'b1;
      cyc(1);
      kick <= 1'b0;
      cyc(3);
      sum += c;
      if (i == 4 || c >= 3 || c <= -3) capFrac += c;
      if (capFrac >= 16)
      begin
        capFrac -= 16;
        cap++;
      end
      rd(ADDR_CAPACITY, 32'hffff, 32'(cap));
    end
    rd(ADDR_VOLT, 32'hffff, 32'h1000);
    bus(1'b1, ADDR_DESCAP, 32'h0120);
    bus(1'b1, ADDR_EDV1, 32'h0800);
    bus(1'b1, ADDR_EDVF, 32'h0400);
    bus(1'b1, ADDR_IRQMASK, 32'h1 << IRQ_EDV1);
    voltIn <= 16'h0700;
    cyc(20);
    rd(ADDR_CAPACITY, 32'hffff, 32'h0012);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_IRQSTAT, 32'h1 << IRQ_EDV1);
    cyc(2);
    chk(irq, 1'b0);
    voltIn <= 16'h0300;
    cyc(20);
    rd(ADDR_CAPACITY, 32'hffff, 32'h0);
    rd(ADDR_STATUS, 32'h30, 32'h30);
    rd(ADDR_CURRENT, 32'hffff, 32'(sum / 5));
    commLine <= 1'b0;
    cyc(40);
    rd(ADDR_STATUS, 32'h4, 32'h4);
    commLine <= 1'b1;
    cyc(8);
    chk(sleepMode, 1'b0);
    rd(8'hfc, 32'hffffffff, 32'h0);
    rstDo(1'b0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    cyc(61);
    offIn <= 16'(offB);
    cyc(46);
    chk(calMode, 1'b0);
    cyc(90);
    rd(ADDR_INTOFF, 32'hffff, 32'(offA));
    rstDo(1'b1);
    cyc(150);
    chk(calMode, 1'b1);
    rd(ADDR_STATUS, 32'h2, 32'h0);
    cyc(200);
    chk(calMode, 1'b0);
    rd(ADDR_INTOFF, 32'hffff, 32'(offA));
    condChange <= 1'b1;
    cyc(1);
    condChange <= 1'b0;
    cyc(5);
    chk(calMode, 1'b1);
    giveVerdict;
  end
endmodule
